/* shared/pec_consts.svh */
// Constants of the partition error capture block: offsets, fields, codes.
// Assumes a 32-bit register bus with byte addresses and 12 address bits.
`ifndef PEC_CONSTS_SVH
`define PEC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PEC_OFS_FEATURE   12'h000
`define PEC_OFS_ECR       12'h0F0
`define PEC_OFS_ESR       12'h0F8
`define PEC_OFS_ESR_HI    12'h0FC

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PEC_ESR_OVR_BIT   31
`define PEC_ESR_CAUSE_HI  27
`define PEC_ESR_CAUSE_LO  24
`define PEC_ESR_PMG_HI    23
`define PEC_ESR_PMG_LO    16
`define PEC_ESR_PID_HI    15
`define PEC_ESR_PID_LO    0
`define PEC_ESR_RIS_HI    3
`define PEC_ESR_RIS_LO    0
`define PEC_ECR_EN_BIT    0
`define PEC_FEAT_NRW_BIT  0
`define PEC_FEAT_EXT_BIT  1
`define PEC_FEAT_RIS_BIT  2
`define PEC_PROT_NS_BIT   1

// ----------------------------------------------------------------------
// Cause codes
// ----------------------------------------------------------------------
`define PEC_C_NONE        4'h0
`define PEC_C_SEL_RANGE   4'h1
`define PEC_C_REQ_PID     4'h2
`define PEC_C_MONCFG_ID   4'h3
`define PEC_C_REQ_PMG     4'h4
`define PEC_C_MON_RANGE   4'h5
`define PEC_C_NRW_RANGE   4'h6
`define PEC_C_UNEXP_NRW   4'h7
`define PEC_C_RIS_PART    4'h8
`define PEC_C_RIS_NOCTL   4'h9
`define PEC_C_RIS_MON     4'hA
`define PEC_C_RIS_NOMON   4'hB

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define PEC_RST_PID       16'h0000
`define PEC_RST_PMG       8'h00
`define PEC_RST_RIS       4'h0
`define PEC_RST_WORD      32'h0000_0000
`define PEC_RESP_OKAY     2'h0
`define PEC_RESP_SLVERR   2'h2

`endif

/* shared/pec_pkg.sv */
// Types shared by the partition error capture block and its bench.
// Assumes the constants header is compiled alongside.
package pec_pkg;

   typedef logic [15:0] pec_id_t;
   typedef logic [7:0]  pec_pmg_t;
   typedef logic [3:0]  pec_ris_t;
   typedef logic [3:0]  pec_cause_t;

   // Kind of register access that the configuration front end reports.
   typedef enum logic [2:0] {
      PEC_TGT_PART_SEL = 3'b000,
      PEC_TGT_CFG      = 3'b001,
      PEC_TGT_NRW_MAP  = 3'b010,
      PEC_TGT_MON_CFG  = 3'b011,
      PEC_TGT_MON_REG  = 3'b100
   } pec_target_e;

   typedef struct packed {
      pec_cause_t cause;
      pec_pmg_t   perf_monitor_group;
      pec_id_t    pid;
      pec_ris_t   resource_instance_sel;
   } pec_synd_s;

endpackage

/* hw/pec_error_capture.sv */
// Error detection, classification and status capture for a resource
// partitioning component, with secure and non-secure status instances.
// Assumes a configuration front end that reports each register access as
// a one-cycle strobe, a request stream, and an AXI4-Lite master.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "pec_consts.svh"

module pec_error_capture #(
   parameter bit               NRW_PRESENT   = 1'b1,
   parameter bit               EXT_PRESENT   = 1'b1,
   parameter bit               RIS_PRESENT   = 1'b1,
   parameter logic [15:0]      RIS_IMPL_MASK = 16'h0003,
   parameter pec_pkg::pec_id_t PID_MAX_S     = 16'h003F,
   parameter pec_pkg::pec_id_t PID_MAX_NS    = 16'h003F,
   parameter pec_pkg::pec_id_t NRW_MAX_S     = 16'h000F,
   parameter pec_pkg::pec_id_t NRW_MAX_NS    = 16'h000F,
   parameter pec_pkg::pec_pmg_t PMG_MAX_S    = 8'h03,
   parameter pec_pkg::pec_pmg_t PMG_MAX_NS   = 8'h03,
   parameter pec_pkg::pec_id_t MON_MAX       = 16'h0007,
   parameter pec_pkg::pec_id_t PID_DEFAULT   = 16'h0000,
   parameter pec_pkg::pec_pmg_t PMG_DEFAULT  = 8'h00
) (
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   // Register bus.
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic [2:0]           s_axi_awprot,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic [2:0]           s_axi_arprot,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // Configuration access report.
   input  wire logic                 cfg_valid,
   input  wire logic                 cfg_write,
   input  wire logic                 cfg_ns,
   input  wire pec_pkg::pec_target_e cfg_target,
   input  wire pec_pkg::pec_id_t     cfg_selected_partition,
   input  wire logic                 cfg_sel_narrowed,
   input  wire pec_pkg::pec_ris_t    cfg_ris,
   input  wire logic                 cfg_ris_has_func,
   input  wire pec_pkg::pec_id_t     cfg_narrowed_partition,
   input  wire logic                 cfg_map_narrowed,
   input  wire pec_pkg::pec_id_t     cfg_monitor_index,
   input  wire pec_pkg::pec_id_t     cfg_mon_partition,
   input  wire pec_pkg::pec_pmg_t    cfg_mon_group,
   output logic                      cfg_reject,
   // Request stream.
   input  wire logic                 req_valid,
   input  wire logic                 req_ns,
   input  wire pec_pkg::pec_id_t     req_partition_id,
   input  wire pec_pkg::pec_pmg_t    req_perf_monitor_group,
   output logic                      out_valid,
   output logic                      out_ns,
   output pec_pkg::pec_id_t          out_partition_id,
   output pec_pkg::pec_pmg_t         out_perf_monitor_group,
   output logic                      out_mon_exclude,
   // Error interrupts.
   output logic                      irq_secure,
   output logic                      irq_nonsecure
);
   import pec_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (RIS_PRESENT && RIS_IMPL_MASK == 16'h0000) begin : g_chk_ris
      $error("Instance selection present but no instance implemented.");
   end
   if (NRW_MAX_S > PID_MAX_S || NRW_MAX_NS > PID_MAX_NS) begin : g_chk_nrw
      $error("Narrowed space cannot exceed the partition space.");
   end

   function automatic logic pec_over(input pec_id_t v, input pec_id_t lim);
      return v > lim;
   endfunction

   function automatic logic pec_ris_bad(input pec_ris_t r);
      return RIS_PRESENT && !RIS_IMPL_MASK[r];
   endfunction

   // ----------------------------------------------------------------------
   // Configuration access classification
   // ----------------------------------------------------------------------
   pec_synd_s c_syn;
   pec_id_t   c_pid_max;
   pec_id_t   c_nrw_max;
   pec_pmg_t  c_pmg_max;
   pec_ris_t  c_ris_opt;
   pec_id_t   c_sel_max;

   always_comb begin
      c_syn     = '{`PEC_C_NONE, `PEC_RST_PMG, `PEC_RST_PID, `PEC_RST_RIS};
      c_pid_max = cfg_ns ? PID_MAX_NS : PID_MAX_S;
      c_nrw_max = cfg_ns ? NRW_MAX_NS : NRW_MAX_S;
      c_pmg_max = cfg_ns ? PMG_MAX_NS : PMG_MAX_S;
      c_sel_max = (NRW_PRESENT && cfg_sel_narrowed) ? c_nrw_max : c_pid_max;
      c_ris_opt = (EXT_PRESENT && RIS_PRESENT) ? cfg_ris : `PEC_RST_RIS;
      if (cfg_valid) begin
         unique case (cfg_target)
            PEC_TGT_PART_SEL: begin
               if (cfg_write && pec_over(cfg_selected_partition, c_sel_max))
               begin
                  c_syn = '{`PEC_C_SEL_RANGE, `PEC_RST_PMG,
                            cfg_selected_partition, c_ris_opt};
               end
            end
            PEC_TGT_CFG, PEC_TGT_NRW_MAP: begin
               if (pec_ris_bad(cfg_ris)) begin
                  c_syn = '{`PEC_C_RIS_PART, `PEC_RST_PMG,
                            cfg_selected_partition, cfg_ris};
               end else if (!cfg_ris_has_func) begin
                  c_syn = '{`PEC_C_RIS_NOCTL, `PEC_RST_PMG,
                            cfg_selected_partition, cfg_ris};
               end else if (NRW_PRESENT && cfg_target == PEC_TGT_NRW_MAP
                            && cfg_sel_narrowed) begin
                  c_syn = '{`PEC_C_UNEXP_NRW, `PEC_RST_PMG,
                            cfg_selected_partition, `PEC_RST_RIS};
               end else if (NRW_PRESENT && cfg_target == PEC_TGT_CFG
                            && !cfg_sel_narrowed) begin
                  c_syn = '{`PEC_C_NRW_RANGE, `PEC_RST_PMG,
                            cfg_selected_partition, `PEC_RST_RIS};
               end else if (NRW_PRESENT && cfg_target == PEC_TGT_NRW_MAP
                            && cfg_write && (!cfg_map_narrowed ||
                            pec_over(cfg_narrowed_partition, c_nrw_max)))
               begin
                  c_syn = '{`PEC_C_NRW_RANGE, `PEC_RST_PMG,
                            cfg_narrowed_partition,
                            `PEC_RST_RIS};
               end else if (cfg_write &&
                            pec_over(cfg_selected_partition, c_sel_max))
               begin
                  c_syn = '{`PEC_C_SEL_RANGE, `PEC_RST_PMG,
                            cfg_selected_partition, c_ris_opt};
               end
            end
            PEC_TGT_MON_CFG: begin
               if (pec_ris_bad(cfg_ris)) begin
                  c_syn = '{`PEC_C_RIS_MON, `PEC_RST_PMG,
                            cfg_monitor_index, cfg_ris};
               end else if (cfg_write && pec_over(cfg_monitor_index, MON_MAX))
               begin
                  c_syn = '{`PEC_C_MON_RANGE, `PEC_RST_PMG,
                            cfg_monitor_index, c_ris_opt};
               end else if (cfg_write &&
                            (pec_over(cfg_mon_partition, c_pid_max) ||
                             cfg_mon_group > c_pmg_max)) begin
                  c_syn = '{`PEC_C_MONCFG_ID, cfg_mon_group,
                            cfg_mon_partition, c_ris_opt};
               end
            end
            PEC_TGT_MON_REG: begin
               if (pec_ris_bad(cfg_ris)) begin
                  c_syn = '{`PEC_C_RIS_MON, `PEC_RST_PMG,
                            cfg_monitor_index, cfg_ris};
               end else if (!cfg_ris_has_func) begin
                  c_syn = '{`PEC_C_RIS_NOMON, `PEC_RST_PMG,
                            cfg_monitor_index, cfg_ris};
               end else if (cfg_write && pec_over(cfg_monitor_index, MON_MAX))
               begin
                  c_syn = '{`PEC_C_MON_RANGE, `PEC_RST_PMG,
                            cfg_monitor_index, c_ris_opt};
               end
            end
            default: c_syn.cause = `PEC_C_NONE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Request checking and remapping
   // ----------------------------------------------------------------------
   pec_synd_s r_syn;
   logic      r_pid_bad;
   logic      r_pmg_bad;
   logic      out_valid_nxt;
   logic      out_ns_nxt;
   pec_id_t   out_pid_nxt;
   pec_pmg_t  out_pmg_nxt;
   logic      out_excl_nxt;
   logic      cfg_reject_nxt;

   always_comb begin
      r_pid_bad = pec_over(req_partition_id, req_ns ? PID_MAX_NS : PID_MAX_S);
      r_pmg_bad = req_perf_monitor_group > (req_ns ? PMG_MAX_NS : PMG_MAX_S);
      r_syn     = '{`PEC_C_NONE, `PEC_RST_PMG, `PEC_RST_PID, `PEC_RST_RIS};
      if (req_valid && r_pid_bad) begin
         r_syn = '{`PEC_C_REQ_PID, req_perf_monitor_group,
                   req_partition_id, `PEC_RST_RIS};
      end else if (req_valid && r_pmg_bad) begin
         r_syn = '{`PEC_C_REQ_PMG, req_perf_monitor_group,
                   req_partition_id, `PEC_RST_RIS};
      end
      // Requests always pass; only their identifiers may change.
      out_valid_nxt  = req_valid;
      out_ns_nxt     = req_ns;
      out_pid_nxt    = r_pid_bad ? PID_DEFAULT : req_partition_id;
      out_pmg_nxt    = r_pmg_bad ? PMG_DEFAULT
                                 : req_perf_monitor_group;
      out_excl_nxt   = req_valid && r_pmg_bad;
      cfg_reject_nxt = c_syn.cause != `PEC_C_NONE;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_valid              <= 1'b0;
         out_ns                 <= 1'b0;
         out_partition_id       <= `PEC_RST_PID;
         out_perf_monitor_group <= `PEC_RST_PMG;
         out_mon_exclude        <= 1'b0;
         cfg_reject             <= 1'b0;
      end else if (ce) begin
         out_valid              <= out_valid_nxt;
         out_ns                 <= out_ns_nxt;
         out_partition_id       <= out_pid_nxt;
         out_perf_monitor_group <= out_pmg_nxt;
         out_mon_exclude        <= out_excl_nxt;
         cfg_reject             <= cfg_reject_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------------
   logic [11:0] wa_r, wa_nxt;
   logic        wns_r, wns_nxt;
   logic        aw_have_r, aw_have_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic [3:0]  ws_r, ws_nxt;
   logic        w_have_r, w_have_nxt;
   logic        awready_nxt, wready_nxt, bvalid_nxt;
   logic [1:0]  bresp_nxt, rresp_nxt;
   logic        arready_nxt, rvalid_nxt;
   logic [31:0] rdata_nxt;
   logic        wr_do;
   logic [31:0] esr_lo [2];
   logic [31:0] esr_hi [2];
   logic        ecr_en_r [2];
   logic        rd_ns;

   function automatic logic pec_mapped(input logic [11:0] a);
      return a == `PEC_OFS_FEATURE || a == `PEC_OFS_ECR ||
             a == `PEC_OFS_ESR || a == `PEC_OFS_ESR_HI;
   endfunction

   always_comb begin
      wa_nxt      = wa_r;
      wns_nxt     = wns_r;
      aw_have_nxt = aw_have_r;
      wd_nxt      = wd_r;
      ws_nxt      = ws_r;
      w_have_nxt  = w_have_r;
      bvalid_nxt  = s_axi_bvalid;
      bresp_nxt   = s_axi_bresp;
      wr_do       = 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_awvalid && s_axi_awready) begin
         wa_nxt      = s_axi_awaddr;
         wns_nxt     = s_axi_awprot[`PEC_PROT_NS_BIT];
         aw_have_nxt = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wd_nxt     = s_axi_wdata;
         ws_nxt     = s_axi_wstrb;
         w_have_nxt = 1'b1;
      end
      if (aw_have_r && w_have_r && !s_axi_bvalid) begin
         wr_do       = 1'b1;
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = pec_mapped(wa_r) ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
      end
      awready_nxt = !aw_have_nxt && !bvalid_nxt;
      wready_nxt  = !w_have_nxt && !bvalid_nxt;

      rvalid_nxt = s_axi_rvalid;
      rdata_nxt  = s_axi_rdata;
      rresp_nxt  = s_axi_rresp;
      rd_ns      = s_axi_arprot[`PEC_PROT_NS_BIT];
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = pec_mapped(s_axi_araddr) ? `PEC_RESP_OKAY
                                               : `PEC_RESP_SLVERR;
         rdata_nxt  = `PEC_RST_WORD;
         unique case (s_axi_araddr)
            `PEC_OFS_FEATURE: begin
               rdata_nxt[`PEC_FEAT_NRW_BIT] = NRW_PRESENT;
               rdata_nxt[`PEC_FEAT_EXT_BIT] = EXT_PRESENT;
               rdata_nxt[`PEC_FEAT_RIS_BIT] = RIS_PRESENT;
            end
            `PEC_OFS_ECR:    rdata_nxt[`PEC_ECR_EN_BIT] = ecr_en_r[rd_ns];
            `PEC_OFS_ESR:    rdata_nxt = esr_lo[rd_ns];
            `PEC_OFS_ESR_HI: rdata_nxt = esr_hi[rd_ns];
            default:         rdata_nxt = `PEC_RST_WORD;
         endcase
      end
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wa_r          <= `PEC_OFS_FEATURE;
         wns_r         <= 1'b0;
         aw_have_r     <= 1'b0;
         wd_r          <= `PEC_RST_WORD;
         ws_r          <= 4'h0;
         w_have_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PEC_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `PEC_RST_WORD;
         s_axi_rresp   <= `PEC_RESP_OKAY;
      end else if (ce) begin
         wa_r          <= wa_nxt;
         wns_r         <= wns_nxt;
         aw_have_r     <= aw_have_nxt;
         wd_r          <= wd_nxt;
         ws_r          <= ws_nxt;
         w_have_r      <= w_have_nxt;
         s_axi_awready <= awready_nxt;
         s_axi_wready  <= wready_nxt;
         s_axi_bvalid  <= bvalid_nxt;
         s_axi_bresp   <= bresp_nxt;
         s_axi_arready <= arready_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         s_axi_rdata   <= rdata_nxt;
         s_axi_rresp   <= rresp_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Status and control instances, index 0 secure and 1 non-secure
   // ----------------------------------------------------------------------
   logic irq_r [2];

   for (genvar gi = 0; gi < 2; gi++) begin : g_inst
      logic       c_hit, r_hit, ev;
      pec_synd_s  ev_syn;
      logic [31:0] lo_r, lo_nxt, sw_lo;
      pec_ris_t   ris_r, ris_nxt;
      logic       en_nxt, irq_nxt;

      always_comb begin
         c_hit  = c_syn.cause != `PEC_C_NONE && cfg_ns == gi[0];
         r_hit  = r_syn.cause != `PEC_C_NONE && req_ns == gi[0];
         ev     = c_hit || r_hit;
         ev_syn = r_hit ? r_syn : c_syn;
         sw_lo  = lo_r;
         for (int b = 0; b < 4; b++) begin
            if (ws_r[b]) begin
               sw_lo[b*8 +: 8] = wd_r[b*8 +: 8];
            end
         end
         lo_nxt  = lo_r;
         ris_nxt = ris_r;
         en_nxt  = ecr_en_r[gi];
         if (wr_do && wns_r == gi[0]) begin
            if (wa_r == `PEC_OFS_ESR) begin
               lo_nxt = sw_lo;
            end
            if (wa_r == `PEC_OFS_ESR_HI && ws_r[0]) begin
               ris_nxt = wd_r[`PEC_ESR_RIS_HI:`PEC_ESR_RIS_LO];
            end
            if (wa_r == `PEC_OFS_ECR && ws_r[0]) begin
               en_nxt = wd_r[`PEC_ECR_EN_BIT];
            end
         end
         // A fresh error takes precedence over a software write to the status words; an ECR write still lands.
         if (ev) begin
            lo_nxt = `PEC_RST_WORD;
            lo_nxt[`PEC_ESR_CAUSE_HI:`PEC_ESR_CAUSE_LO] = ev_syn.cause;
            lo_nxt[`PEC_ESR_PMG_HI:`PEC_ESR_PMG_LO] = ev_syn.perf_monitor_group;
            lo_nxt[`PEC_ESR_PID_HI:`PEC_ESR_PID_LO] = ev_syn.pid;
            lo_nxt[`PEC_ESR_OVR_BIT] =
               (lo_r[`PEC_ESR_CAUSE_HI:`PEC_ESR_CAUSE_LO] != `PEC_C_NONE)
               || (c_hit && r_hit);
            ris_nxt = ev_syn.resource_instance_sel;
         end
         irq_nxt = en_nxt && lo_nxt[`PEC_ESR_CAUSE_HI:`PEC_ESR_CAUSE_LO]
                   != `PEC_C_NONE;
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            lo_r         <= `PEC_RST_WORD;
            ris_r        <= `PEC_RST_RIS;
            ecr_en_r[gi] <= 1'b0;
            irq_r[gi]    <= 1'b0;
         end else if (ce) begin
            lo_r         <= lo_nxt;
            ris_r        <= ris_nxt;
            ecr_en_r[gi] <= en_nxt;
            irq_r[gi]    <= irq_nxt;
         end
      end

      always_comb begin
         esr_lo[gi] = lo_r;
         esr_hi[gi] = {28'h0000000, ris_r};
      end
   end

   always_comb begin
      irq_secure    = irq_r[0];
      irq_nonsecure = irq_r[1];
   end

endmodule

/* dv/pec_monitor.sv */
// Port checker of the error capture block.
// Assumes equal secure and non-secure limits, takes the secure ones; bound to every instance.
`timescale 1ns/10ps
module pec_monitor #(parameter logic [15:0] PM = 16'h003F,
   parameter logic [7:0] GM = 8'h03, parameter logic [15:0] RM = 16'h0003) (
   input wire logic ref_clk, rst, ce, req_valid, req_ns, out_valid, out_ns,
   input wire logic out_mon_exclude, cfg_valid, cfg_reject, s_axi_bvalid,
   input wire logic s_axi_bready, s_axi_rvalid, s_axi_rready,
   input wire logic [15:0] req_partition_id, out_partition_id,
   input wire logic [7:0] req_perf_monitor_group, out_perf_monitor_group,
   input wire logic [3:0] cfg_ris,
   input wire pec_pkg::pec_target_e cfg_target);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence rq_s; req_valid && ce; endsequence
   pid_fix_a: assert property (rq_s ##0 req_partition_id > PM |=>
      out_partition_id == 0) else $error("bad partition kept");
   pmg_fix_a: assert property (rq_s ##0 req_partition_id <= PM &&
      req_perf_monitor_group > GM |=> out_perf_monitor_group == 0 &&
      out_mon_exclude) else $error("bad group kept");
   req_fwd_a: assert property (rq_s |=> out_valid &&
      out_ns == $past(req_ns)) else $error("request lost");
   id_keep_a: assert property (rq_s ##0 req_partition_id <= PM &&
      req_perf_monitor_group <= GM |=> out_partition_id ==
      $past(req_partition_id) && !out_mon_exclude) else $error("ids altered");
   ris_rej_a: assert property (cfg_valid && ce && !RM[cfg_ris] &&
      cfg_target != pec_pkg::PEC_TGT_PART_SEL &&
      cfg_target <= pec_pkg::PEC_TGT_MON_REG |=> cfg_reject)
      else $error("no reject");
   no_rej_a: assert property (ce && !cfg_valid |=> !cfg_reject)
      else $error("stray reject");
   b_done_a: assert property (ce && s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid) else $error("write answer stuck");
   r_done_a: assert property (ce && s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid) else $error("read answer stuck");
endmodule
bind pec_error_capture pec_monitor #(.PM(PID_MAX_S), .GM(PMG_MAX_S),
   .RM(RIS_IMPL_MASK)) pec_monitor_inst (.*);

/* dv/pec_req_source.sv */
// Request source standing in for the system bus requesters.
// Assumes the bench issues one request per call.
`timescale 1ns/10ps
module pec_req_source (
   input  wire logic ref_clk,
   output logic req_valid = 0, req_ns = 0,
   output logic [15:0] req_partition_id = 0,
   output logic [7:0] req_perf_monitor_group = 0);
   task automatic send(logic ns, logic [15:0] v, logic [7:0] m);
      @(posedge ref_clk);
      {req_valid, req_ns, req_partition_id, req_perf_monitor_group} <=
         {1'b1, ns, v, m};
      @(posedge ref_clk);
      // Idle lines show the inverse so a stale copy is never mistaken.
      {req_valid, req_ns, req_partition_id, req_perf_monitor_group} <=
         {1'b0, ~ns, ~v, ~m};
      #1;
   endtask
endmodule

/* dv/tb_pec_error_capture.sv */
// Self-checking bench of the error capture block.
// Assumes default limits: partitions to 3F, groups to 3, instances 0, 1.
`timescale 1ns/10ps
`include "pec_consts.svh"
module tb_pec_error_capture;
   import pec_pkg::*;
   logic ref_clk = 0, rst = 1, ce = 1, cfg_write = 1, cfg_ris_has_func = 1;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, cfg_ns = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, cfg_valid = 0, req_ns;
   logic cfg_sel_narrowed = 0, cfg_map_narrowed = 0, s_axi_awready, req_valid;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cfg_reject;
   logic out_valid, out_ns, out_mon_exclude, irq_secure, irq_nonsecure;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   pec_target_e cfg_target = PEC_TGT_CFG;
   pec_id_t cfg_selected_partition = 0, cfg_narrowed_partition = 0, p;
   pec_id_t cfg_monitor_index = 0, cfg_mon_partition = 0;
   pec_id_t req_partition_id, out_partition_id;
   pec_pmg_t cfg_mon_group = 0, req_perf_monitor_group, out_perf_monitor_group, g;
   pec_ris_t cfg_ris = 0, r;
   int num_errors = 0, tests_run = 0, n;
   always #10 ref_clk = ~ref_clk;
   pec_error_capture pec_error_capture_inst (.*);
   pec_req_source pec_req_source_inst (.*);
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(logic [11:0] a, logic ns, logic [31:0] d);
      @(posedge ref_clk);
      {s_axi_awaddr, s_axi_awprot, s_axi_wdata} <= {a, 1'b0, ns, 1'b0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      s_axi_bready <= 0;
      rs = s_axi_bresp;
      if (n >= 50) begin
         num_errors++;
         final_report;
      end
   endtask
   task automatic rd(logic [11:0] a, logic ns);
      @(posedge ref_clk);
      {s_axi_araddr, s_axi_arprot} <= {a, 1'b0, ns, 1'b0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      {rdv, rs} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 0;
      if (n >= 50) begin
         num_errors++;
         final_report;
      end
   endtask
   task automatic cfg(pec_ris_t ri, pec_id_t v);
      @(posedge ref_clk);
      {cfg_valid, cfg_ns, cfg_ris, cfg_selected_partition} <= {2'h3, ri, v};
      {cfg_sel_narrowed, cfg_map_narrowed, cfg_narrowed_partition,
         cfg_mon_partition, cfg_mon_group} <= 42'({$urandom, $urandom});
      @(posedge ref_clk);
      cfg_valid <= 0;
      #1;
   endtask
   function automatic logic [31:0] esr(logic o, pec_cause_t c, pec_id_t v);
      return {o, 3'h0, c, g, v};
   endfunction
   initial begin
      n = $urandom(88064);
      repeat (6) @(posedge ref_clk);
      rst <= 0;
      wr(`PEC_OFS_ECR, 0, 1);
      wr(`PEC_OFS_ECR, 1, 1);
      chk("bresp ok", 32'(rs), 32'(`PEC_RESP_OKAY));
      p = 16'h0040 + 16'($urandom_range(16'hFFBF));
      g = 8'($urandom_range(3));
      pec_req_source_inst.send(0, p, g);
      chk("irq_secure", 32'(irq_secure), 1);
      rd(`PEC_OFS_ESR, 0);
      chk("cause 2", rdv, esr(0, `PEC_C_REQ_PID, p));
      p = 16'($urandom_range(63));
      g = 8'h04 + 8'($urandom_range(251));
      pec_req_source_inst.send(0, p, g);
      rd(`PEC_OFS_ESR, 0);
      chk("cause 4", rdv, esr(1, `PEC_C_REQ_PMG, p));
      wr(`PEC_OFS_ESR, 0, 0);
      rd(`PEC_OFS_ESR, 0);
      chk("cleared", rdv, 0);
      chk("irq_secure low", 32'(irq_secure), 0);
      r = 4'h2 + 4'($urandom_range(13));
      g = 0;
      cfg(r, p);
      chk("irq_nonsecure", 32'(irq_nonsecure), 1);
      rd(`PEC_OFS_ESR, 1);
      chk("cause 8", rdv, esr(0, `PEC_C_RIS_PART, p));
      wr(`PEC_OFS_ECR, 1, 0);
      rd(`PEC_OFS_ESR_HI, 1);
      chk("instance", rdv, 32'(r));
      chk("irq masked", 32'(irq_nonsecure), 0);
      rd(12'h800, 0);
      chk("unmapped", 32'(rs), 32'(`PEC_RESP_SLVERR));
      wr(12'h800, 1, 32'hFFFF_FFFF);
      chk("bresp", 32'(rs), 32'(`PEC_RESP_SLVERR));
      cfg_target <= PEC_TGT_MON_REG;
      cfg_ris_has_func <= 0;
      cfg(1, p);
      rd(`PEC_OFS_ESR, 1);
      chk("cause 11", rdv, esr(1, `PEC_C_RIS_NOMON, 0));
      repeat (20) pec_req_source_inst.send(1'($urandom),
         16'($urandom_range(63)), 8'($urandom_range(3)));
      @(posedge ref_clk) ce <= 0;
      pec_req_source_inst.send(0, 16'hFFFF, 0);
      @(posedge ref_clk) ce <= 1;
      rd(`PEC_OFS_ESR, 0);
      chk("frozen", rdv, 0);
      final_report;
   end
endmodule
